//--- encdw_enc_model.sv
`timescale 1ns/1ps
`default_nettype none
module encdw_enc_model
    import encdw_pkg::*;
(
    input  wire logic        clk,
    output var encdw_enc_in_t enc
);
    logic a_q  = 1'b0;
    logic b_q  = 1'b0;
    logic i_q  = 1'b0;
    int   hold = 20;
    assign enc = {a_q, ~a_q, b_q, ~b_q, i_q, ~i_q};
    task automatic drive(input logic a, input logic b, input logic i, input int n);
        @(negedge clk);
        a_q = a;
        b_q = b;
        i_q = i;
        repeat (n) @(negedge clk);
    endtask : drive
    task automatic quad(input logic up);
        if (up) drive(~b_q, a_q, i_q, hold);
        else drive(b_q, ~a_q, i_q, hold);
    endtask : quad
    task automatic pulse(input logic up);
        drive(1'b0, up, i_q, hold);
        drive(1'b1, up, i_q, hold);
        drive(1'b0, up, i_q, hold);
    endtask : pulse
endmodule : encdw_enc_model
`default_nettype wire

//--- encdw_pkg.sv
`default_nettype none

package encdw_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS     = 4000;
    localparam int MAX_CYCLE_RATE_HZ = 3000000;
    localparam int MAX_COUNT_RATE_HZ = 12000000;
    localparam int MIN_EDGE_NS       = 1000000000 / MAX_COUNT_RATE_HZ;
    localparam int MIN_EDGE_CYC      = (MIN_EDGE_NS * 1000) / CLK_PERIOD_PS;
    localparam int FILT_CYC_DEF      = 2;
    localparam int WDOG_TIMEOUT_US   = 1000;
    localparam int WDOG_TIMEOUT_CYC  = (WDOG_TIMEOUT_US * 1000000) / CLK_PERIOD_PS;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int          POS_W      = 32;
    localparam int          FILT_W     = 3;
    localparam int          WDOG_W     = 32;
    localparam int          CH_A       = 2;
    localparam int          CH_B       = 1;
    localparam int          CH_IDX     = 0;
    localparam logic [POS_W-1:0] POS_RST = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        STEP_NONE = 2'b00,
        STEP_UP   = 2'b01,
        STEP_DOWN = 2'b10
    } encdw_step_t;

    typedef enum logic [1:0] {
        WD_POWERUP = 2'b00,
        WD_RUN     = 2'b01,
        WD_TRIPPED = 2'b10
    } encdw_wd_state_t;

    typedef struct packed {
        logic encoder_phase_a_p;
        logic encoder_phase_a_n;
        logic encoder_phase_b_p;
        logic encoder_phase_b_n;
        logic index_p;
        logic index_n;
    } encdw_enc_in_t;

    typedef struct packed {
        logic diff_mode;
        logic pulse_dir_mode;
        logic index_sync_en;
        logic index_clear_en;
    } encdw_axis_cfg_t;

    typedef struct packed {
        logic [2:0]       raw;
        logic [FILT_W-1:0] stab;
        logic [2:0]       filt;
        logic [POS_W-1:0] pos;
        logic [POS_W-1:0] idx_pos;
        logic             idx_evt;
    } encdw_axis_st_t;

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic encdw_line(input logic p, input logic n, input logic diff,
                                        input logic hold);
        if (!diff) begin
            return p;
        end
        return (p != n) ? p : hold;
    endfunction : encdw_line

    function automatic encdw_step_t encdw_qstep(input logic [1:0] prev, input logic [1:0] cur);
        encdw_step_t s;
        s = STEP_NONE;
        unique case ({prev, cur})
            4'b0010, 4'b1011, 4'b1101, 4'b0100: s = STEP_UP;
            4'b0001, 4'b0111, 4'b1110, 4'b1000: s = STEP_DOWN;
            default:                            s = STEP_NONE;
        endcase
        return s;
    endfunction : encdw_qstep

endpackage : encdw_pkg

`default_nettype wire

//--- encdw_sva.sv
`timescale 1ns/1ps
`default_nettype none
module encdw_sva
    import encdw_pkg::*;
#(
    parameter int NUM_AXES         = 2,
    parameter int WDOG_TIMEOUT_CLK = WDOG_TIMEOUT_CYC
) (
    input wire logic                           MCLK,
    input wire logic                           RESET,
    input wire encdw_enc_in_t   [NUM_AXES-1:0] ENC_IN,
    input wire encdw_axis_cfg_t [NUM_AXES-1:0] AXIS_CFG,
    input wire logic                           WDOG_KICK,
    input wire logic [NUM_AXES-1:0][POS_W-1:0] POSITION,
    input wire logic [NUM_AXES-1:0][POS_W-1:0] INDEX_POSITION,
    input wire logic [NUM_AXES-1:0]            INDEX_EVENT,
    input wire logic [NUM_AXES-1:0]            AXIS_ERROR,
    input wire logic                           AMP_ENABLE_OUT
);
    int idle_q;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);
    // Cycles since the last kick while enabled, saturating after a trip
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            idle_q <= 0;
        end else if (WDOG_KICK && AMP_ENABLE_OUT) begin
            idle_q <= 0;
        end else if ((AMP_ENABLE_OUT || idle_q != 0) && idle_q < WDOG_TIMEOUT_CLK + 4) begin
            idle_q <= idle_q + 1;
        end
    end
    sequence s_rel;
        $past(RESET) && !RESET;
    endsequence
    sequence s_idx;
        INDEX_EVENT[0] && !AXIS_CFG[0].index_clear_en;
    endsequence
    a_reset_off: assert property (disable iff (1'b0) RESET |-> !AMP_ENABLE_OUT)
        else $error("amp enabled in reset");
    a_err_all: assert property (AXIS_ERROR == {NUM_AXES{!AMP_ENABLE_OUT}})
        else $error("error lights wrong");
    a_powerup_exit: assert property (s_rel |-> !AMP_ENABLE_OUT ##1 AMP_ENABLE_OUT)
        else $error("amp not enabled after power-up");
    a_run_enable: assert property (idle_q inside {[1:WDOG_TIMEOUT_CLK-2]} |-> AMP_ENABLE_OUT)
        else $error("amp dropped early");
    a_trip_bound: assert property (idle_q > WDOG_TIMEOUT_CLK + 2 |-> !AMP_ENABLE_OUT)
        else $error("watchdog trip late");
    a_trip_holds: assert property ($fell(AMP_ENABLE_OUT) |=> !AMP_ENABLE_OUT [*8])
        else $error("amp back without reset");
    a_step_one: assert property ($changed(POSITION[0]) && !INDEX_EVENT[0]
        |-> (POSITION[0] - $past(POSITION[0])) inside {32'h1, 32'hffff_ffff})
        else $error("count jump");
    a_filt_stable: assert property ($changed(POSITION[0])
        |-> $past(ENC_IN[0]) == $past(ENC_IN[0], 2)) else $error("unfiltered count");
    a_pulse_dir: assert property (AXIS_CFG[0].pulse_dir_mode && $changed(POSITION[0]) |->
        POSITION[0] - $past(POSITION[0]) == ($past(ENC_IN[0].encoder_phase_b_p) ? 1 : 32'hffff_ffff))
        else $error("pulse direction wrong");
    a_idx_latch: assert property (s_idx |-> INDEX_POSITION[0] == POSITION[0] ##1 !INDEX_EVENT[0])
        else $error("index capture wrong");
    a_idx_clear: assert property (INDEX_EVENT[1] && AXIS_CFG[1].index_clear_en |-> POSITION[1] == '0)
        else $error("index clear wrong");
endmodule : encdw_sva
bind encdw_top encdw_sva #(.NUM_AXES(NUM_AXES), .WDOG_TIMEOUT_CLK(WDOG_TIMEOUT_CLK)) u_sva (
    .MCLK(MCLK), .RESET(RESET), .ENC_IN(ENC_IN), .AXIS_CFG(AXIS_CFG), .WDOG_KICK(WDOG_KICK),
    .POSITION(POSITION), .INDEX_POSITION(INDEX_POSITION), .INDEX_EVENT(INDEX_EVENT),
    .AXIS_ERROR(AXIS_ERROR), .AMP_ENABLE_OUT(AMP_ENABLE_OUT));
`default_nettype wire

//--- encdw_top.sv
`timescale 1ns/1ps
`default_nettype none

module encdw_top
    import encdw_pkg::*;
#(
    parameter int NUM_AXES         = 2,
    parameter int FILT_CYC         = FILT_CYC_DEF,
    parameter int WDOG_TIMEOUT_CLK = WDOG_TIMEOUT_CYC
) (
    input  wire logic                            MCLK,
    input  wire logic                            RESET,
    input  wire encdw_enc_in_t   [NUM_AXES-1:0]  ENC_IN,
    input  wire encdw_axis_cfg_t [NUM_AXES-1:0]  AXIS_CFG,
    input  wire logic                            WDOG_KICK,
    output logic [NUM_AXES-1:0][POS_W-1:0]       POSITION,
    output logic [NUM_AXES-1:0][POS_W-1:0]       INDEX_POSITION,
    output logic [NUM_AXES-1:0]                  INDEX_EVENT,
    output logic [NUM_AXES-1:0]                  AXIS_ERROR,
    output logic                                 AMP_ENABLE_OUT
);

    // ------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------
    initial begin
        if (NUM_AXES < 1) begin
            $error("NUM_AXES must be at least 1");
        end
        if (FILT_CYC < 1 || FILT_CYC > 7) begin
            $error("FILT_CYC must lie in 1..7");
        end
        if (FILT_CYC + 2 >= MIN_EDGE_CYC) begin
            $error("FILT_CYC too long for the maximum count rate");
        end
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        encdw_axis_st_t [NUM_AXES-1:0] ax;
    } encdw_state_t;

    encdw_state_t state_q;
    encdw_state_t state_d;

    logic wd_amp_en;
    logic wd_fault;

    // ------------------------------------------------------------------
    // Per-axis decode
    // ------------------------------------------------------------------
    always_comb begin
        encdw_axis_st_t  cur;
        encdw_axis_cfg_t cfg;
        encdw_enc_in_t   pin;
        encdw_step_t     step;
        logic [2:0]      raw;
        logic [2:0]      nfilt;
        logic [POS_W-1:0] npos;
        cur     = '0;
        cfg     = '0;
        pin     = '0;
        step    = STEP_NONE;
        raw     = '0;
        nfilt   = '0;
        npos    = '0;
        state_d = state_q;
        for (int i = 0; i < NUM_AXES; i++) begin
            cur = state_q.ax[i];
            cfg = AXIS_CFG[i];
            pin = ENC_IN[i];

            // Line receivers, differential pair or single-ended
            raw[CH_A]   = encdw_line(pin.encoder_phase_a_p, pin.encoder_phase_a_n,
                                     cfg.diff_mode, cur.raw[CH_A]);
            raw[CH_B]   = encdw_line(pin.encoder_phase_b_p, pin.encoder_phase_b_n,
                                     cfg.diff_mode, cur.raw[CH_B]);
            raw[CH_IDX] = encdw_line(pin.index_p, pin.index_n,
                                     cfg.diff_mode, cur.raw[CH_IDX]);

            // Glitch filter, short against the fastest legal edge spacing
            if (raw == cur.raw) begin
                if (cur.stab < FILT_W'(FILT_CYC - 1)) begin
                    state_d.ax[i].stab = cur.stab + FILT_W'(1);
                end
            end else begin
                state_d.ax[i].stab = '0;
            end
            state_d.ax[i].raw = raw;
            if (raw == cur.raw && cur.stab >= FILT_W'(FILT_CYC - 1)) begin
                nfilt = raw;
            end else begin
                nfilt = cur.filt;
            end
            state_d.ax[i].filt = nfilt;

            // Count step
            npos = cur.pos;
            if (cfg.pulse_dir_mode) begin
                step = STEP_NONE;
                if (!cur.filt[CH_A] && nfilt[CH_A]) begin
                    step = nfilt[CH_B] ? STEP_UP : STEP_DOWN;
                end
            end else begin
                step = encdw_qstep(cur.filt[CH_A:CH_B], nfilt[CH_A:CH_B]);
            end
            unique case (step)
                STEP_UP:   npos = cur.pos + POS_W'(1);
                STEP_DOWN: npos = cur.pos - POS_W'(1);
                STEP_NONE: npos = cur.pos;
                default:   npos = cur.pos;
            endcase

            // Index reference
            state_d.ax[i].idx_evt = 1'b0;
            if (cfg.index_sync_en && !cur.filt[CH_IDX] && nfilt[CH_IDX]) begin
                state_d.ax[i].idx_pos = npos;
                state_d.ax[i].idx_evt = 1'b1;
                if (cfg.index_clear_en) begin
                    npos = POS_RST;
                end
            end
            state_d.ax[i].pos = npos;
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            for (int i = 0; i < NUM_AXES; i++) begin
                state_q.ax[i].raw     <= '0;
                state_q.ax[i].stab    <= '0;
                state_q.ax[i].filt    <= '0;
                state_q.ax[i].pos     <= POS_RST;
                state_q.ax[i].idx_pos <= POS_RST;
                state_q.ax[i].idx_evt <= 1'b0;
            end
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------------
    encdw_wdog #(
        .TIMEOUT_CYC (WDOG_TIMEOUT_CLK)
    ) u_wdog (
        .clk    (MCLK),
        .rst    (RESET),
        .kick   (WDOG_KICK),
        .amp_en (wd_amp_en),
        .fault  (wd_fault)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NUM_AXES; i++) begin
            POSITION[i]       = state_q.ax[i].pos;
            INDEX_POSITION[i] = state_q.ax[i].idx_pos;
            INDEX_EVENT[i]    = state_q.ax[i].idx_evt;
        end
    end

    assign AXIS_ERROR     = {NUM_AXES{wd_fault}};
    assign AMP_ENABLE_OUT = wd_amp_en;

endmodule : encdw_top

`default_nettype wire

//--- encdw_wdog.sv
`timescale 1ns/1ps
`default_nettype none

module encdw_wdog
    import encdw_pkg::*;
#(
    parameter int TIMEOUT_CYC = WDOG_TIMEOUT_CYC
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic kick,
    output logic      amp_en,
    output logic      fault
);

    initial begin
        if (TIMEOUT_CYC < 2) begin
            $error("TIMEOUT_CYC must be at least 2");
        end
    end

    typedef struct packed {
        encdw_wd_state_t   st;
        logic [WDOG_W-1:0] cnt;
        logic              amp_en;
        logic              fault;
    } encdw_wd_t;

    encdw_wd_t state_q;
    encdw_wd_t state_d;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q.st)
            WD_POWERUP: begin
                state_d.st  = WD_RUN;
                state_d.cnt = '0;
            end
            WD_RUN: begin
                if (kick) begin
                    state_d.cnt = '0;
                end else if (state_q.cnt >= WDOG_W'(TIMEOUT_CYC - 1)) begin
                    state_d.st = WD_TRIPPED;
                end else begin
                    state_d.cnt = state_q.cnt + WDOG_W'(1);
                end
            end
            WD_TRIPPED: begin
                state_d.st = WD_TRIPPED;
            end
            default: begin
                state_d.st = WD_TRIPPED;
            end
        endcase
        state_d.amp_en = (state_d.st == WD_RUN);
        state_d.fault  = (state_d.st != WD_RUN);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q.st     <= WD_POWERUP;
            state_q.cnt    <= '0;
            state_q.amp_en <= 1'b0;
            state_q.fault  <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    assign amp_en = state_q.amp_en;
    assign fault  = state_q.fault;

endmodule : encdw_wdog

`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import encdw_pkg::*;
;
    localparam int T = 16;
    logic                  mclk      = 1'b0;
    logic                  reset     = 1'b1;
    logic                  wdog_kick = 1'b0;
    logic                  kick_en   = 1'b0;
    logic [31:0]           rng       = 32'h45;
    wire encdw_enc_in_t    [1:0] enc;
    encdw_axis_cfg_t [1:0] cfg       = {4'b1011, 4'b0110};
    logic [1:0][POS_W-1:0] pos;
    logic [1:0][POS_W-1:0] ipos;
    logic [1:0]            iev;
    logic [1:0]            aerr;
    logic                  amp;
    int                    error_cnt = 0;
    int                    checked   = 0;
    int                    exp_pos[2] = '{0, 0};
    int                    ev_cnt[2]  = '{0, 0};
    encdw_top #(.NUM_AXES(2), .FILT_CYC(2), .WDOG_TIMEOUT_CLK(T)) DUT (.MCLK(mclk), .RESET(reset),
        .ENC_IN(enc), .AXIS_CFG(cfg), .WDOG_KICK(wdog_kick), .POSITION(pos),
        .INDEX_POSITION(ipos), .INDEX_EVENT(iev), .AXIS_ERROR(aerr), .AMP_ENABLE_OUT(amp));
    encdw_enc_model m0 (.clk(mclk), .enc(enc[0]));
    encdw_enc_model m1 (.clk(mclk), .enc(enc[1]));
    initial forever #2 mclk = ~mclk;
    always @(negedge mclk) wdog_kick <= kick_en & ~wdog_kick;
    always @(negedge mclk) begin
        ev_cnt[0] += int'(iev[0]);
        ev_cnt[1] += int'(iev[1]);
    end
    // --------
    // Tasks
    // --------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic summarize();
        $display("errors %0d of %0d checks", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize
    task automatic do_reset();
        reset = 1'b1;
        repeat (3) @(negedge mclk);
        cmp({aerr, amp}, 3'b110);
        reset = 1'b0;
        @(negedge mclk);
        cmp({aerr, amp}, 3'b001);
        cmp(pos[0] | pos[1], 32'h0);
    endtask : do_reset
    task automatic move(input int ax, input logic pd);
        logic up;
        rng = xs(rng);
        up = rng[0];
        if (ax == 1) m1.quad(up);
        else if (pd) m0.pulse(up);
        else m0.quad(up);
        exp_pos[ax] += up ? 1 : -1;
        cmp(pos[ax], exp_pos[ax]);
    endtask : move
    // --------
    // Main sequence
    // --------
    initial begin
        do_reset();
        kick_en <= 1'b1;
        for (int i = 0; i < 10; i++) move(0, 1'b1);
        cfg[0].pulse_dir_mode = 1'b0;
        for (int i = 0; i < 40; i++) move(i % 2, 1'b0);
        m0.drive(~m0.a_q, ~m0.b_q, 1'b0, m0.hold);
        cmp(pos[0], exp_pos[0]);
        m0.drive(~m0.a_q, m0.b_q, 1'b0, 0);
        m0.drive(~m0.a_q, m0.b_q, 1'b0, m0.hold);
        cmp(pos[0], exp_pos[0]);
        m0.drive(m0.a_q, m0.b_q, 1'b1, m0.hold);
        m1.drive(m1.a_q, m1.b_q, 1'b1, m1.hold);
        cmp(ipos[0], exp_pos[0]);
        cmp(ipos[1], exp_pos[1]);
        exp_pos[1] = 0;
        m0.drive(m0.a_q, m0.b_q, 1'b0, m0.hold);
        cfg[0].index_sync_en = 1'b0;
        m0.drive(m0.a_q, m0.b_q, 1'b1, m0.hold);
        for (int i = 0; i < 4; i++) move(1, 1'b0);
        cmp({ev_cnt[0] == 1, ev_cnt[1] == 1}, 2'b11);
        kick_en <= 1'b0;
        repeat (T - 3) @(negedge mclk);
        cmp({aerr, amp}, 3'b001);
        for (int k = 0; k < 12 && amp !== 1'b0; k++) @(negedge mclk);
        cmp({aerr, amp}, 3'b110);
        if (amp !== 1'b0) summarize();
        kick_en <= 1'b1;
        m0.drive(1'b0, 1'b0, 1'b0, m0.hold);
        m1.drive(1'b0, 1'b0, 1'b0, m1.hold);
        cmp({aerr, amp}, 3'b110);
        do_reset();
        exp_pos = '{0, 0};
        for (int i = 0; i < 6; i++) move(i % 2, 1'b0);
        summarize();
    end
    initial begin
        repeat (20000) @(negedge mclk);
        error_cnt++;
        summarize();
    end
endmodule : testbench
`default_nettype wire
